/* File: rtl/awm_pkg.sv */
// Package: constants, states and carriers for the async word memory host controller
package awm_pkg;
  // Memory organisation
  localparam int ADDR_W = 18;  // Word address width
  localparam int DATA_W = 16;  // Word width
  localparam int LANE_W = 8;   // Byte lane width
  // Clock rate
  localparam int CLK_PERIOD_PS = 8000;  // core_clk period, ps
  // Printed times in ns
  localparam int T_CYCLE_NS      = 35;  // Least cycle time (fall to fall of select)
  localparam int T_PULSE_NS      = 15;  // Least write pulse width
  localparam int T_ADDR_WH_NS    = 20;  // Address valid to end of write, gate low case
  localparam int T_DATA_SETUP_NS = 10;  // Data valid to end of write
  localparam int T_RECOVER_NS    = 12;  // Write recovery
  localparam int T_ACCESS_NS     = 35;  // Read access time
  localparam int T_HIGH_HOLD_NS  = 2;   // Strobe must stay high at least this long
  // Least time to cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SETUP_CYC   = CNT_W'(1);  // Address/data settle before strobe
  localparam logic [CNT_W-1:0] PULSE_CYC   = CNT_W'(ns_to_cyc(T_ADDR_WH_NS));
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(ns_to_cyc(T_RECOVER_NS));
  localparam logic [CNT_W-1:0] ACCESS_CYC  = CNT_W'(ns_to_cyc(T_ACCESS_NS));
  localparam logic [CNT_W-1:0] CYCLE_CYC   = CNT_W'(ns_to_cyc(T_CYCLE_NS));
  localparam logic [CNT_W-1:0] HIGH_CYC    = CNT_W'(ns_to_cyc(T_HIGH_HOLD_NS));
  // Sequencer states
  typedef enum logic [2:0] {
    AWM_IDLE, AWM_SETUP, AWM_STROBE, AWM_RECOVER, AWM_READ, AWM_GAP
  } awm_state_t;
  // User request carrier
  typedef struct packed {
    logic              write;   // 1 write, 0 read
    logic [ADDR_W-1:0] addr;    // Word address
    logic [DATA_W-1:0] wdata;   // Write data
    logic [1:0]        lanes;   // [1] high lane, [0] low lane, active high
  } awm_req_t;
  // Memory pin carrier (all strobes active low)
  typedef struct packed {
    logic              chip_sel_n;
    logic              write_n;
    logic              out_gate_n;
    logic              high_lane_enable_n;
    logic              low_lane_enable_n;
    logic [ADDR_W-1:0] addr;
  } awm_pins_t;
  // Idle pin levels
  localparam awm_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
endpackage : awm_pkg

/* File: rtl/awm_in_sync.sv */
// Two-flop synchroniser for the memory data pins
`timescale 1ns/1ps
`default_nettype none
module awm_in_sync #(
  parameter int W = 16
) (
  // Clock, reset, enable
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;  // First stage, read only by second stage
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;  // Second stage
  logic [W-1:0] sync_next;

  // Next values: hold while enable is low
  always_comb
  begin
    meta_next = clk_en ? async_in : meta_reg;
    sync_next = clk_en ? meta_reg : sync_reg;
  end

  // Register both stages
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : awm_in_sync
`default_nettype wire

/* File: rtl/awm_host_ctrl.sv */
// Host controller driving an async 16-bit word memory through its pins
// Function
// - Write only while select and strobe low
// - Select falls spaced by least cycle time
// - Lane enables bound write, 3 cycles (24 ns)
// - Address stable across one whole cycle
// - Strobe held high in read cycles
`timescale 1ns/1ps
`default_nettype none
module awm_host_ctrl
(
  // Clock, reset, enable
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // User request side
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire awm_pkg::awm_req_t        req,
  // User answer side
  output logic                          rsp_valid,
  output logic [awm_pkg::DATA_W-1:0]    rsp_rdata,
  // Memory control and address pins
  output awm_pkg::awm_pins_t            mem_pins,
  // Memory data pins, three signals
  input  wire logic [awm_pkg::DATA_W-1:0] mem_dq_in,
  output logic [awm_pkg::DATA_W-1:0]    mem_dq_out,
  output logic                          mem_dq_oe_n
);
  import awm_pkg::*;

  awm_state_t          state_reg, state_next;      // Sequencer state
  logic [CNT_W-1:0]    cnt_reg, cnt_next;          // Phase counter
  logic [CNT_W-1:0]    since_reg, since_next;      // Cycles since select fell
  awm_req_t            cur_reg, cur_next;          // Captured request
  awm_pins_t           pins_reg, pins_next;        // Registered pin levels
  logic [DATA_W-1:0]   dq_reg, dq_next;            // Write data driven
  logic                oe_n_reg, oe_n_next;        // Data drive enable, low drives
  logic                rv_reg, rv_next;            // Answer pulse
  logic [DATA_W-1:0]   rd_reg, rd_next;            // Read data
  logic [DATA_W-1:0]   dq_sync;                    // Synchronised data pins
  logic                spacing_ok;                 // Next select fall allowed

  // Data pins come from outside the clock domain
  awm_in_sync #(.W(DATA_W)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (mem_dq_in),
    .sync_out (dq_sync)
  );

  // Next select fall only once the least cycle time has passed
  assign spacing_ok = (since_reg >= CYCLE_CYC);
  // Accept only in idle with spacing satisfied
  assign req_ready  = clk_en && (state_reg == AWM_IDLE) && spacing_ok;

  // Countdown helpers shared by the strobe, recovery, read and gap phases; a count of one or zero ends the phase,
  // so a zero left over from reset can never wrap round to the top of the counter
  function automatic logic last_beat(input logic [CNT_W-1:0] c);
    return (c <= CNT_W'(1));
  endfunction : last_beat

  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    return CNT_W'(c - 1'b1);
  endfunction : count_down

  // Sequencer next-state logic
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cur_next   = cur_reg;
    pins_next  = pins_reg;
    dq_next    = dq_reg;
    oe_n_next  = oe_n_reg;
    rv_next    = 1'b0;
    rd_next    = rd_reg;
    // Saturating count since the last select fall
    since_next = (since_reg == CYCLE_CYC) ? since_reg : CNT_W'(since_reg + 1'b1);
    case (state_reg)
      AWM_IDLE:
      begin
        if (req_valid && spacing_ok)
        begin
          cur_next       = req;
          pins_next      = PINS_IDLE;
          pins_next.addr = req.addr;
          cnt_next       = SETUP_CYC;
          if (req.write)
          begin
            // Address, data and select first; strobe later so select leads it
            pins_next.out_gate_n = 1'b1;
            pins_next.chip_sel_n = 1'b0;
            since_next           = '0;
            dq_next              = req.wdata;
            oe_n_next            = 1'b0;
            state_next           = AWM_SETUP;
          end
          else
          begin
            // Read: strobe stays high throughout
            pins_next.write_n            = 1'b1;
            pins_next.chip_sel_n         = 1'b0;
            pins_next.out_gate_n         = 1'b0;
            pins_next.low_lane_enable_n  = 1'b0;
            pins_next.high_lane_enable_n = 1'b0;
            since_next                   = '0;
            oe_n_next                    = 1'b1;
            cnt_next                     = ACCESS_CYC;
            state_next                   = AWM_READ;
          end
        end
      end
      AWM_SETUP:
      begin
        // Open the window: strobe and lanes low together, select already low
        pins_next.write_n            = 1'b0;
        pins_next.low_lane_enable_n  = ~cur_reg.lanes[0];
        pins_next.high_lane_enable_n = ~cur_reg.lanes[1];
        cnt_next                     = PULSE_CYC;
        state_next                   = AWM_STROBE;
      end
      AWM_STROBE:
      begin
        if (!last_beat(cnt_reg))
          cnt_next = count_down(cnt_reg);
        else
        begin
          // Close: strobe and lanes rise, select kept low one more cycle
          pins_next.write_n            = 1'b1;
          pins_next.low_lane_enable_n  = 1'b1;
          pins_next.high_lane_enable_n = 1'b1;
          cnt_next                     = RECOVER_CYC;
          state_next                   = AWM_RECOVER;
        end
      end
      AWM_RECOVER:
      begin
        // Select rises after strobe; address and data held for recovery
        pins_next.chip_sel_n = 1'b1;
        if (!last_beat(cnt_reg))
          cnt_next = count_down(cnt_reg);
        else
        begin
          oe_n_next  = 1'b1;
          rv_next    = 1'b1;
          cnt_next   = HIGH_CYC;
          state_next = AWM_GAP;
        end
      end
      AWM_READ:
      begin
        if (!last_beat(cnt_reg))
          cnt_next = count_down(cnt_reg);
        else
        begin
          // Word taken here stood on the pins two edges earlier, so the
          // access window has to cover the synchroniser's lag as well
          rd_next    = dq_sync;
          rv_next    = 1'b1;
          pins_next  = PINS_IDLE;
          pins_next.addr = cur_reg.addr;
          cnt_next   = HIGH_CYC;
          state_next = AWM_GAP;
        end
      end
      AWM_GAP:
      begin
        // Strobes stay high at least the least high time
        if (!last_beat(cnt_reg))
          cnt_next = count_down(cnt_reg);
        else
          state_next = AWM_IDLE;
      end
      default:
      begin
        state_next = AWM_IDLE;
        pins_next  = PINS_IDLE;
        oe_n_next  = 1'b1;
      end
    endcase
  end

  // Register all sequencer state, frozen while enable is low
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= AWM_IDLE;
      cnt_reg   <= '0;
      since_reg <= CYCLE_CYC;
      cur_reg   <= '0;
      pins_reg  <= PINS_IDLE;
      dq_reg    <= '0;
      oe_n_reg  <= 1'b1;
      rv_reg    <= 1'b0;
      rd_reg    <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      since_reg <= since_next;
      cur_reg   <= cur_next;
      pins_reg  <= pins_next;
      dq_reg    <= dq_next;
      oe_n_reg  <= oe_n_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
    end
  end

  assign mem_pins    = pins_reg;
  assign mem_dq_out  = dq_reg;
  assign mem_dq_oe_n = oe_n_reg;
  assign rsp_valid   = rv_reg;
  assign rsp_rdata   = rd_reg;
endmodule : awm_host_ctrl
`default_nettype wire

/* File: dv/awm_chk_assertions.sv */
// Checker for pin timing of the async word memory host controller
`timescale 1ns/1ps
`default_nettype none
module awm_chk
(
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  // Answer and memory pins
  input wire logic                       rsp_valid,
  input wire awm_pkg::awm_pins_t         mem_pins,
  input wire logic [awm_pkg::DATA_W-1:0] mem_dq_out,
  input wire logic                       mem_dq_oe_n
);
  import awm_pkg::*;
  // Short names for the strobes
  wire logic cs = mem_pins.chip_sel_n;
  wire logic we = mem_pins.write_n;
  wire logic og = mem_pins.out_gate_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_gate_wr; !we |-> og; endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gate low in strobe");
  property p_sel_first; $fell(we) |-> !$past(cs); endproperty
  a_sel_first: assert property (p_sel_first) else $error("select late");
  property p_sel_last; $rose(we) |-> !cs; endproperty
  a_sel_last: assert property (p_sel_last) else $error("select rose early");
  property p_space; $fell(cs) |=> (!$fell(cs))[*4]; endproperty
  a_space: assert property (p_space) else $error("select falls too close");
  property p_pulse; $fell(we) |-> (!we)[*3] ##1 we; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe length wrong");
  property p_addr; !cs && !$fell(cs) |-> $stable(mem_pins.addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in cycle");
  property p_rd_we; !og |-> we; endproperty
  a_rd_we: assert property (p_rd_we) else $error("strobe low in read");
  property p_data; !we |-> !mem_dq_oe_n && $stable(mem_dq_out); endproperty
  a_data: assert property (p_data) else $error("data not held in write");
  property p_wr_done; $fell(cs) && og |-> ##6 rsp_valid; endproperty
  a_wr_done: assert property (p_wr_done) else $error("write answer late");
  property p_rd_done; $fell(og) |-> ##5 rsp_valid; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read answer late");
endmodule : awm_chk
bind awm_host_ctrl awm_chk i_chk (.core_clk, .rst_n, .rsp_valid, .mem_pins, .mem_dq_out,
  .mem_dq_oe_n);
`default_nettype wire

/* File: dv/awm_mem_model.sv */
// Behavioural model of the word memory seen from its pins
`timescale 1ns/1ps
`default_nettype none
module awm_mem_model
(
  // Clock for the released-bus pattern
  input wire logic                       core_clk,
  // Pins from the host
  input wire awm_pkg::awm_pins_t         mem_pins,
  input wire logic [awm_pkg::DATA_W-1:0] dq_out,
  input wire logic                       dq_oe_n,
  // Resolved data wire
  output logic [awm_pkg::DATA_W-1:0]     mem_dq_in
);
  import awm_pkg::*;
  logic [DATA_W-1:0] mem [16];  // Small store, address folds on bits 3:0
  logic [DATA_W-1:0] last = '0; // Last wire level
  int                clash_cnt = 0;
  wire logic [3:0] a = mem_pins.addr[3:0];
  wire logic wr_on = !mem_pins.chip_sel_n && !mem_pins.write_n;
  // Drives only when gated, strobe high and selected; never inside a write
  wire logic rd_on = !mem_pins.chip_sel_n && !mem_pins.out_gate_n && mem_pins.write_n;
  // Store while the overlap lasts, per enabled lane
  always @*
    if (wr_on)
    begin
      if (!mem_pins.low_lane_enable_n) mem[a][7:0] = dq_out[7:0];
      if (!mem_pins.high_lane_enable_n) mem[a][15:8] = dq_out[15:8];
    end
  // Released wire shows the inverse of its last level, never a held value
  assign mem_dq_in = !dq_oe_n ? dq_out : rd_on ? mem[a] : ~last;
  always @(posedge core_clk)
  begin
    last <= mem_dq_in;
    if (rd_on && !dq_oe_n) clash_cnt++;
  end
endmodule : awm_mem_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Testbench for the async word memory host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import awm_pkg::*;
  logic               core_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               req_valid = 1'b0;
  awm_req_t           req = '0;
  logic               req_ready, rsp_valid, oe_n;
  logic [DATA_W-1:0]  rsp_rdata, dq_in, dq_out, q;
  awm_pins_t          mem_pins;
  int                 err_total = 0;
  int                 samples_checked = 0;
  always #4 core_clk = ~core_clk;
  awm_host_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_pins(mem_pins), .mem_dq_in(dq_in), .mem_dq_out(dq_out),
    .mem_dq_oe_n(oe_n));
  awm_mem_model i_mem (.core_clk(core_clk), .mem_pins(mem_pins), .dq_out(dq_out),
    .dq_oe_n(oe_n), .mem_dq_in(dq_in));
  // Verdict and end of run
  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // One request, held until taken, then wait for its answer
  task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] d,
                      input logic [1:0] l);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{w, a, d, l};
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 50) err_total++;
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 50) err_total++;
    q = rsp_rdata;
  endtask : xfer
  // Full word stored and read back
  task automatic t_full;
    xfer(1'b1, 18'h00002, 16'hFFFF, 2'h3);
    xfer(1'b0, 18'h00002, 16'h0000, 2'h3);
    `CHK(q, 16'hFFFF)
  endtask : t_full
  // Each lane alone, then none
  task automatic t_lanes;
    xfer(1'b1, 18'h00002, 16'h1234, 2'h1);
    xfer(1'b0, 18'h00002, 16'h0000, 2'h3);
    `CHK(q, 16'hFF34)
    xfer(1'b1, 18'h00002, 16'h5678, 2'h2);
    xfer(1'b0, 18'h00002, 16'h0000, 2'h3);
    `CHK(q, 16'h5634)
    xfer(1'b1, 18'h00002, 16'hABCD, 2'h0);
    xfer(1'b0, 18'h00002, 16'h0000, 2'h3);
    `CHK(q, 16'h5634)
  endtask : t_lanes
  // Back-to-back writes to the top address and to address 5, no bus fight
  task automatic t_b2b;
    xfer(1'b1, 18'h3FFFF, 16'hC35A, 2'h3);
    xfer(1'b1, 18'h00005, 16'h0F1E, 2'h3);
    xfer(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
    `CHK(q, 16'hC35A)
    xfer(1'b0, 18'h00005, 16'h0000, 2'h3);
    `CHK(q, 16'h0F1E)
    `CHK(i_mem.clash_cnt, 0)
  endtask : t_b2b
  // Reset cut into a write: pins fall back to idle, stored words survive
  task automatic t_reset;
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{1'b1, 18'h00007, 16'h1357, 2'h3};
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 50) err_total++;
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(mem_pins.write_n, 1'b0)
    rst_n = 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(mem_pins, PINS_IDLE)
    `CHK(oe_n, 1'b1)
    `CHK(rsp_valid, 1'b0)
    @(posedge core_clk);
    #1 rst_n = 1'b1;
    `CHK(req_ready, 1'b1)
    xfer(1'b0, 18'h00005, 16'h0000, 2'h3);
    `CHK(q, 16'h0F1E)
  endtask : t_reset
  // Watchdog: far beyond the hundred or so cycles the tests need
  initial
  begin
    #(8 * 5000);
    err_total++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_full();
    t_lanes();
    t_b2b();
    t_reset();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
